// [bench/ptg_load_model.sv]
// behavioural actuator load that watches the pulse output and measures it
module ptg_load_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic pulse,
    output logic [31:0] rises,
    output logic [31:0] high_len,
    output logic [31:0] period_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_q;
    logic [31:0] hcnt_q;
    logic [31:0] pcnt_q;

    // a load only sees the pin: widths are counted in whole clock cycles
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            prev_q <= 1'b0;
            rises <= 32'h0;
            hcnt_q <= 32'h0;
            pcnt_q <= 32'h0;
            high_len <= 32'h0;
            period_len <= 32'h0;
        end else begin
            prev_q <= pulse;
            if (pulse && !prev_q) begin
                rises <= rises + 32'h1;
                // first rise has no previous edge to measure from
                if (rises != 32'h0) begin
                    period_len <= pcnt_q;
                end
                pcnt_q <= 32'h1;
                hcnt_q <= 32'h1;
            end else begin
                pcnt_q <= pcnt_q + 32'h1;
                if (pulse) begin
                    hcnt_q <= hcnt_q + 32'h1;
                end else if (prev_q) begin
                    high_len <= hcnt_q;
                end
            end
        end
    end
endmodule

// [bench/ptg_top_tb_top.sv]
// self-checking testbench for the pulse train generator
module ptg_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] T_PER = 32'h0000_0190;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic trg = 1'b0;
    logic gen_rst = 1'b0;
    logic clr = 1'b0;
    ptg_pkg::ptg_cfg_s cfg = '0;
    logic pulse_q;
    logic active_q;
    logic [31:0] running_value_word_q;
    logic [31:0] rises;
    logic [31:0] high_len;
    logic [31:0] period_len;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    ptg_top uut (
        .clk(clk),
        .rst(rst),
        .trg(trg),
        .gen_rst(gen_rst),
        .cfg(cfg),
        .pulse_q(pulse_q),
        .active_q(active_q),
        .running_value_word_q(running_value_word_q)
    );

    ptg_load_model load (
        .clk(clk),
        .rst(rst),
        .clr(clr),
        .pulse(pulse_q),
        .rises(rises),
        .high_len(high_len),
        .period_len(period_len)
    );

    always #12.5 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ceiling well above the roughly 70k cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            mismatches++;
            $display("MISMATCH %0t timeout", $time);
            print_verdict();
        end
    end

    task automatic chk1(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic set_cfg(input logic [1:0] mode, input logic [26:0] n, input logic [16:0] f, input logic [6:0] d);
        @(negedge clk);
        cfg = '0;
        cfg.mode = ptg_pkg::ptg_mode_e'(mode);
        cfg.pulse_num = n;
        cfg.freq = f;
        cfg.duty = d;
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
    endtask

    // one-cycle trigger pulse, then look for the busy flag
    task automatic fire();
        @(negedge clk);
        trg = 1'b1;
        @(negedge clk);
        trg = 1'b0;
        @(posedge clk);
        #1;
        chk1(active_q, 1'b1, "active after trigger");
    endtask

    task automatic wait_idle(input int limit);
        int k;
        k = 0;
        while (active_q !== 1'b0 && k < limit) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk1(active_q, 1'b0, "train finished in time");
    endtask

    task automatic t_fixed();
        set_cfg(2'h0, 27'h000_0002, 17'h1_86A0, 7'h00);
        fire();
        repeat (100) @(negedge clk);
        trg = 1'b1;
        @(negedge clk);
        trg = 1'b0;
        wait_idle(2000);
        chk32(running_value_word_q, 32'h2, "fixed running value");
        chk32(rises, 32'h2, "fixed pulse count");
        chk32(high_len, T_PER / 2, "fixed high time");
        chk32(period_len, T_PER, "fixed period");
        chk1(pulse_q, 1'b0, "fixed idle low");
        // mode code 3 runs as fixed duty; frequency above range clamps to max
        set_cfg(2'h3, 27'h000_0001, 17'h1_FFFF, 7'h00);
        fire();
        wait_idle(2000);
        chk32(running_value_word_q, 32'h1, "retrigger restarts count");
        chk32(high_len, T_PER / 2, "clamped freq high time");
    endtask

    task automatic t_pwm(input logic [6:0] d, input logic [31:0] exp_high);
        set_cfg(2'h1, 27'h000_0003, 17'h1_86A0, d);
        fire();
        wait_idle(3000);
        chk32(rises, 32'h3, "pwm pulse count");
        chk32(running_value_word_q, 32'h3, "pwm running value");
        chk32(high_len, exp_high, "pwm high time");
        chk32(period_len, T_PER, "pwm period");
    endtask

    task automatic t_cont();
        set_cfg(2'h0, 27'h000_0000, 17'h1_86A0, 7'h00);
        fire();
        repeat (4000) @(negedge clk);
        chk1(active_q, 1'b1, "continuous still running");
        chk1(running_value_word_q >= 32'h9, 1'b1, "continuous keeps counting");
        gen_rst = 1'b1;
        trg = 1'b1;
        @(posedge clk);
        #1;
        chk1(pulse_q, 1'b0, "reset drives output low");
        chk1(active_q, 1'b0, "reset stops train");
        chk32(running_value_word_q, 32'h0, "reset clears running");
        @(negedge clk);
        trg = 1'b0;
        gen_rst = 1'b0;
        repeat (800) @(negedge clk);
        chk1(pulse_q, 1'b0, "stays idle after reset");
        set_cfg(2'h0, 27'h000_0001, 17'h1_86A0, 7'h00);
        fire();
        wait_idle(2000);
        chk32(running_value_word_q, 32'h1, "new train after reset");
    endtask

    // two segments of 20000 cycles: 50 pulses at 400, then 25 at 800
    task automatic t_ramp();
        set_cfg(2'h2, 27'h000_0000, 17'h0_0000, 7'h00);
        @(negedge clk);
        cfg.start_frequency = 17'h1_86A0;
        cfg.end_frequency = 17'h0_C350;
        cfg.ramp_ms = 13'h0001;
        cfg.seg_num = 7'h02;
        fire();
        // three divisions come before the first pulse, so its width lands near cycle 300
        repeat (400) @(negedge clk);
        chk32(high_len, T_PER / 2, "first segment high");
        wait_idle(42000);
        chk32(running_value_word_q, 32'h4B, "ramp pulse total");
        chk32(rises, 32'h4B, "ramp pulses at load");
        chk32(high_len, T_PER, "last segment high");
        chk1(pulse_q, 1'b0, "ramp ends low");
    endtask

    // rising ramp: 25 pulses at 800, then 400-cycle periods; cut short by generator reset
    task automatic t_ramp_up();
        set_cfg(2'h2, 27'h000_0000, 17'h0_0000, 7'h00);
        @(negedge clk);
        cfg.start_frequency = 17'h0_C350;
        cfg.end_frequency = 17'h1_86A0;
        cfg.ramp_ms = 13'h0001;
        cfg.seg_num = 7'h02;
        fire();
        repeat (600) @(negedge clk);
        chk32(high_len, T_PER, "rising first segment high");
        repeat (20000) @(negedge clk);
        chk32(high_len, T_PER / 2, "rising last segment high");
        chk32(running_value_word_q, 32'h1A, "rising ramp running value");
        gen_rst = 1'b1;
        @(negedge clk);
        gen_rst = 1'b0;
        chk1(active_q, 1'b0, "reset cuts ramp");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk1(pulse_q, 1'b0, "reset output low");
        chk32(running_value_word_q, 32'h0, "reset running zero");
        t_fixed();
        t_pwm(7'h19, 32'h64);
        t_pwm(7'h05, 32'h28);
        t_cont();
        t_ramp();
        t_ramp_up();
        print_verdict();
    end
endmodule

// [inc/ptg_pkg.sv]
// constants, config carrier and state codes for the pulse train generator
package ptg_pkg;
    localparam logic [31:0] CLK_HZ = 32'h0262_5A00;
    localparam int CLK_PERIOD_NS = 25;
    localparam logic [31:0] CYC_PER_MS = 32'(1_000_000 / CLK_PERIOD_NS);
    localparam int DIV_W = 32;
    localparam logic [26:0] PULSE_NUM_MAX = 27'h5F5_E0FF;
    localparam logic [16:0] FREQ_MIN = 17'h0_0001;
    localparam logic [16:0] FREQ_MAX = 17'h1_86A0;
    localparam logic [6:0] DUTY_MIN = 7'h0A;
    localparam logic [6:0] DUTY_MAX = 7'h64;
    localparam logic [31:0] PCT_FULL = 32'h0000_0064;
    localparam logic [12:0] RAMP_MS_MIN = 13'h0001;
    localparam logic [12:0] RAMP_MS_MAX = 13'h1388;
    localparam logic [6:0] SEG_MIN = 7'h01;
    localparam logic [6:0] SEG_MAX = 7'h64;

    typedef enum logic [1:0] {
        MODE_FIXED = 2'h0,
        MODE_PWM = 2'h1,
        MODE_RAMP = 2'h2
    } ptg_mode_e;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SEG = 7'h02,
        ST_STEP = 7'h04,
        ST_PER = 7'h08,
        ST_HIGH = 7'h10,
        ST_RUN = 7'h20,
        ST_DONE = 7'h40
    } ptg_state_e;

    typedef struct packed {
        ptg_mode_e mode;
        logic [26:0] pulse_num;
        logic [16:0] freq;
        logic [6:0] duty;
        logic [16:0] start_frequency;
        logic [16:0] end_frequency;
        logic [12:0] ramp_ms;
        logic [6:0] seg_num;
    } ptg_cfg_s;
endpackage

// [verilog/ptg_divider.sv]
// sequential restoring divider, one quotient bit per clock
module ptg_divider #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic [W-1:0] quotient,
    output logic done
);
    logic [W-1:0] rem_q;
    logic [W-1:0] quo_q;
    logic [W-1:0] dvs_q;
    logic [$clog2(W+1)-1:0] cnt_q;
    logic busy_q;
    logic [W:0] trial;

    assign trial = {rem_q, quo_q[W-1]} - {1'b0, dvs_q};
    assign quotient = quo_q;

    // a new start aborts any division still in flight
    always_ff @(posedge clk) begin
        if (rst) begin
            rem_q <= '0;
            quo_q <= '0;
            dvs_q <= '0;
            cnt_q <= '0;
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_q <= '0;
                quo_q <= dividend;
                dvs_q <= divisor;
                cnt_q <= ($clog2(W+1))'(W);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (!trial[W]) begin
                    rem_q <= trial[W-1:0];
                end else begin
                    rem_q <= {rem_q[W-2:0], quo_q[W-1]};
                end
                quo_q <= {quo_q[W-2:0], ~trial[W]};
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == 1) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// [verilog/ptg_top.sv]
// pulse train generator: fixed-duty, variable-duty and ramped pulse trains
// Function
// - fixed-duty train starts on a trigger rising edge
// - generator reset stops any train and returns to idle
// - fixed-duty periods are exactly half high, half low
// - pulse count accepted from zero to its maximum
// - frequency accepted from one to its maximum in hertz
// - pulse count zero means run continuously
// - finite count emits that many pulses; continuous ignores count
// - variable-duty train starts on a trigger rising edge
// - variable-duty period from frequency and duty; stops after count
// - duty accepted from ten to one hundred percent
// - ramp sequence starts on a trigger rising edge
// - ramp time split into equal segments, time over segment count
// - segment frequency steps by difference over segments minus one
// - pulses per segment equal segment time over segment period
// - ramp start and end frequencies accepted from one to maximum
// - ramp time accepted from one to five thousand milliseconds
// - segment count accepted from one to one hundred
// - pulses produced so far shown as a double-word running value
module ptg_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic trg,
    input wire logic gen_rst,
    input wire ptg_pkg::ptg_cfg_s cfg,
    output logic pulse_q,
    output logic active_q,
    output logic [31:0] running_value_word_q
);
    ptg_pkg::ptg_state_e state_q;
    ptg_pkg::ptg_state_e state_d;
    ptg_pkg::ptg_mode_e mode_q;
    ptg_pkg::ptg_mode_e mode_in;
    logic trg_q;
    logic start;
    logic [26:0] target_q;
    logic [6:0] duty_q;
    logic [16:0] sf_q;
    logic [16:0] ef_q;
    logic [12:0] ramp_ms_q;
    logic [6:0] seg_n_q;
    logic up_q;
    logic [16:0] cur_freq_q;
    logic [16:0] step_q;
    logic [6:0] seg_idx_q;
    logic [31:0] period_q;
    logic [31:0] high_q;
    logic [31:0] cnt_q;
    logic [31:0] seg_cycles_q;
    logic [31:0] seg_left_q;
    logic div_wait_q;
    logic div_start;
    logic div_done;
    logic div_ok;
    logic div_state;
    logic [31:0] div_a;
    logic [31:0] div_b;
    logic [31:0] div_q;
    logic run;
    logic ramp;
    logic seg_end;
    logic last_seg;
    logic period_end;
    logic count_hit;
    logic finish;
    logic [16:0] freq_diff;
    logic [16:0] freq_in;
    logic [16:0] sf_in;
    logic [16:0] ef_in;

    function automatic logic [16:0] clamp_freq(input logic [16:0] f);
        logic [16:0] r;
        r = f;
        if (f < ptg_pkg::FREQ_MIN) begin
            r = ptg_pkg::FREQ_MIN;
        end else if (f > ptg_pkg::FREQ_MAX) begin
            r = ptg_pkg::FREQ_MAX;
        end
        return r;
    endfunction

    // an undefined mode code falls back to the fixed-duty train
    assign mode_in = (cfg.mode == ptg_pkg::MODE_PWM || cfg.mode == ptg_pkg::MODE_RAMP) ?
        cfg.mode : ptg_pkg::MODE_FIXED;
    assign freq_in = clamp_freq(cfg.freq);
    assign sf_in = clamp_freq(cfg.start_frequency);
    assign ef_in = clamp_freq(cfg.end_frequency);

    // retrigger is only taken once the previous train is idle or finished
    assign start = trg && !trg_q && !gen_rst &&
        (state_q == ptg_pkg::ST_IDLE || state_q == ptg_pkg::ST_DONE);

    assign run = state_q == ptg_pkg::ST_RUN;
    assign ramp = mode_q == ptg_pkg::MODE_RAMP;
    assign last_seg = seg_idx_q == seg_n_q - 7'h01;
    // a segment ends when its remaining time no longer fits a whole period
    assign seg_end = run && ramp && cnt_q == 32'h0 && seg_left_q < period_q;
    assign period_end = run && !seg_end && cnt_q == period_q - 32'h1;
    assign count_hit = period_end && !ramp && target_q != 27'h0 &&
        running_value_word_q + 32'h1 == 32'(target_q);
    assign finish = (seg_end && last_seg) || count_hit;
    assign freq_diff = up_q ? ef_q - sf_q : sf_q - ef_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            trg_q <= 1'b0;
        end else begin
            trg_q <= trg;
        end
    end

    // configuration is latched per train so changes mid-train do not disturb it
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= ptg_pkg::MODE_FIXED;
            target_q <= 27'h0;
            duty_q <= ptg_pkg::DUTY_MAX;
            sf_q <= ptg_pkg::FREQ_MIN;
            ef_q <= ptg_pkg::FREQ_MIN;
            ramp_ms_q <= ptg_pkg::RAMP_MS_MIN;
            seg_n_q <= ptg_pkg::SEG_MIN;
            up_q <= 1'b1;
        end else if (start) begin
            mode_q <= mode_in;
            target_q <= (cfg.pulse_num > ptg_pkg::PULSE_NUM_MAX) ?
                ptg_pkg::PULSE_NUM_MAX : cfg.pulse_num;
            duty_q <= (cfg.duty < ptg_pkg::DUTY_MIN) ? ptg_pkg::DUTY_MIN :
                (cfg.duty > ptg_pkg::DUTY_MAX) ? ptg_pkg::DUTY_MAX : cfg.duty;
            sf_q <= sf_in;
            ef_q <= ef_in;
            up_q <= ef_in >= sf_in;
            ramp_ms_q <= (cfg.ramp_ms < ptg_pkg::RAMP_MS_MIN) ? ptg_pkg::RAMP_MS_MIN :
                (cfg.ramp_ms > ptg_pkg::RAMP_MS_MAX) ? ptg_pkg::RAMP_MS_MAX : cfg.ramp_ms;
            seg_n_q <= (cfg.seg_num < ptg_pkg::SEG_MIN) ? ptg_pkg::SEG_MIN :
                (cfg.seg_num > ptg_pkg::SEG_MAX) ? ptg_pkg::SEG_MAX : cfg.seg_num;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ptg_pkg::ST_IDLE, ptg_pkg::ST_DONE: begin
                if (start) begin
                    state_d = (mode_in == ptg_pkg::MODE_RAMP) ? ptg_pkg::ST_SEG : ptg_pkg::ST_PER;
                end
            end
            ptg_pkg::ST_SEG: begin
                if (div_ok) begin
                    state_d = (seg_n_q > 7'h01) ? ptg_pkg::ST_STEP : ptg_pkg::ST_PER;
                end
            end
            ptg_pkg::ST_STEP: begin
                if (div_ok) begin
                    state_d = ptg_pkg::ST_PER;
                end
            end
            ptg_pkg::ST_PER: begin
                if (div_ok) begin
                    state_d = (mode_q == ptg_pkg::MODE_PWM) ? ptg_pkg::ST_HIGH : ptg_pkg::ST_RUN;
                end
            end
            ptg_pkg::ST_HIGH: begin
                if (div_ok) begin
                    state_d = ptg_pkg::ST_RUN;
                end
            end
            ptg_pkg::ST_RUN: begin
                if (finish) begin
                    state_d = ptg_pkg::ST_DONE;
                end else if (seg_end) begin
                    state_d = ptg_pkg::ST_PER;
                end
            end
            default: begin
                state_d = ptg_pkg::ST_IDLE;
            end
        endcase
        if (gen_rst) begin
            state_d = ptg_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ptg_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign div_state = state_q == ptg_pkg::ST_SEG || state_q == ptg_pkg::ST_STEP ||
        state_q == ptg_pkg::ST_PER || state_q == ptg_pkg::ST_HIGH;
    assign div_start = div_state && !div_wait_q && !gen_rst;
    // a done left over from an aborted division is not taken
    assign div_ok = div_done && div_wait_q && div_state;

    always_comb begin
        div_a = 32'h0;
        div_b = 32'h1;
        if (state_q == ptg_pkg::ST_SEG) begin
            div_a = 32'(ramp_ms_q) * ptg_pkg::CYC_PER_MS;
            div_b = 32'(seg_n_q);
        end else if (state_q == ptg_pkg::ST_STEP) begin
            div_a = 32'(freq_diff);
            div_b = 32'(seg_n_q - 7'h01);
        end else if (state_q == ptg_pkg::ST_PER) begin
            div_a = ptg_pkg::CLK_HZ;
            div_b = 32'(cur_freq_q);
        end else if (state_q == ptg_pkg::ST_HIGH) begin
            div_a = 32'(period_q * 32'(duty_q));
            div_b = ptg_pkg::PCT_FULL;
        end
    end

    ptg_divider #(
        .W(ptg_pkg::DIV_W)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .start(div_start),
        .dividend(div_a),
        .divisor(div_b),
        .quotient(div_q),
        .done(div_done)
    );

    always_ff @(posedge clk) begin
        if (rst || gen_rst) begin
            div_wait_q <= 1'b0;
        end else if (div_start) begin
            div_wait_q <= 1'b1;
        end else if (div_ok) begin
            div_wait_q <= 1'b0;
        end
    end

    // period timing; odd cycle counts are trimmed so a half-duty period splits evenly
    always_ff @(posedge clk) begin
        if (rst || gen_rst) begin
            period_q <= 32'h2;
            high_q <= 32'h1;
            seg_cycles_q <= 32'h0;
            step_q <= 17'h0;
        end else if (div_ok) begin
            if (state_q == ptg_pkg::ST_SEG) begin
                seg_cycles_q <= div_q;
                step_q <= 17'h0;
            end else if (state_q == ptg_pkg::ST_STEP) begin
                step_q <= div_q[16:0];
            end else if (state_q == ptg_pkg::ST_PER) begin
                period_q <= (mode_q == ptg_pkg::MODE_PWM) ? div_q : {div_q[31:1], 1'b0};
                high_q <= {1'b0, div_q[31:1]};
            end else if (state_q == ptg_pkg::ST_HIGH) begin
                high_q <= div_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || gen_rst) begin
            cnt_q <= 32'h0;
        end else if (start || seg_end || period_end) begin
            cnt_q <= 32'h0;
        end else if (run) begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || gen_rst) begin
            seg_left_q <= 32'h0;
        end else if (div_ok && state_q == ptg_pkg::ST_SEG) begin
            seg_left_q <= div_q;
        end else if (seg_end) begin
            seg_left_q <= seg_cycles_q;
        end else if (run && ramp && seg_left_q != 32'h0) begin
            seg_left_q <= seg_left_q - 32'h1;
        end
    end

    // with two or more segments, the last segment lands exactly on the end frequency despite truncated steps
    always_ff @(posedge clk) begin
        if (rst || gen_rst) begin
            cur_freq_q <= ptg_pkg::FREQ_MIN;
            seg_idx_q <= 7'h0;
        end else if (start) begin
            cur_freq_q <= (mode_in == ptg_pkg::MODE_RAMP) ? sf_in : freq_in;
            seg_idx_q <= 7'h0;
        end else if (seg_end && !last_seg) begin
            seg_idx_q <= seg_idx_q + 7'h01;
            if (seg_idx_q + 7'h02 == seg_n_q) begin
                cur_freq_q <= ef_q;
            end else if (up_q) begin
                cur_freq_q <= cur_freq_q + step_q;
            end else begin
                cur_freq_q <= cur_freq_q - step_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || gen_rst) begin
            running_value_word_q <= 32'h0;
        end else if (start) begin
            running_value_word_q <= 32'h0;
        end else if (period_end) begin
            running_value_word_q <= running_value_word_q + 32'h1;
        end
    end

    // continuous trains never hit the count check and run until reset
    always_ff @(posedge clk) begin
        if (rst || gen_rst) begin
            pulse_q <= 1'b0;
        end else if (!run || finish || seg_end) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= cnt_q < high_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || gen_rst) begin
            active_q <= 1'b0;
        end else if (start) begin
            active_q <= 1'b1;
        end else if (finish) begin
            active_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_start;
        start;
    endsequence

    sequence s_reach_run;
        ##[1:200] (state_q == ptg_pkg::ST_RUN);
    endsequence

    a_reset_clears: assert property (gen_rst |=> !pulse_q && running_value_word_q == 32'h0 &&
        state_q == ptg_pkg::ST_IDLE)
        else $error("generator reset did not clear output and count");
    a_trigger_run: assert property (disable iff (rst || gen_rst) s_start |-> s_reach_run)
        else $error("trigger did not start a train");
    a_half_duty: assert property ((run && mode_q != ptg_pkg::MODE_PWM) |-> {high_q, 1'b0} == period_q)
        else $error("half-duty split wrong");
    a_count_limit: assert property ((!ramp && target_q != 27'h0) |->
        running_value_word_q <= 32'(target_q))
        else $error("pulse count exceeded");
    a_endless_run: assert property ((run && !ramp && target_q == 27'h0 && !gen_rst) |=> run)
        else $error("continuous train stopped");
    a_duty_range: assert property ((active_q && mode_q == ptg_pkg::MODE_PWM) |->
        duty_q >= ptg_pkg::DUTY_MIN && duty_q <= ptg_pkg::DUTY_MAX)
        else $error("duty out of range");
    a_freq_range: assert property (active_q |->
        cur_freq_q >= ptg_pkg::FREQ_MIN && cur_freq_q <= ptg_pkg::FREQ_MAX)
        else $error("frequency out of range");
    a_ramp_params: assert property ((active_q && ramp) |-> seg_n_q <= ptg_pkg::SEG_MAX &&
        seg_n_q >= ptg_pkg::SEG_MIN && ramp_ms_q >= ptg_pkg::RAMP_MS_MIN && ramp_ms_q <= ptg_pkg::RAMP_MS_MAX)
        else $error("ramp settings out of range");
    a_seg_time: assert property ((run && ramp) |-> seg_cycles_q * 32'(seg_n_q) <=
        32'(ramp_ms_q) * ptg_pkg::CYC_PER_MS && seg_left_q <= seg_cycles_q)
        else $error("segment time wrong");
    a_seg_step: assert property ((seg_end && !last_seg && !gen_rst) |=> cur_freq_q == ef_q ||
        (up_q ? cur_freq_q - $past(cur_freq_q) : $past(cur_freq_q) - cur_freq_q) == step_q)
        else $error("segment frequency step wrong");
    a_done_low: assert property ((finish && !gen_rst) |=> (!pulse_q)[*2])
        else $error("output not low after final pulses");
    a_running_step: assert property ((period_end && !gen_rst) |=>
        running_value_word_q == $past(running_value_word_q) + 32'h1)
        else $error("running value did not advance");
endmodule
